/* dv/sswg_checker.sv */
`timescale 1ns/1ns
module sswg_checker
	import sswg_pkg::*;
#(
	parameter int NUM_CORES = 4
) (
	input wire logic                 CLK_SYS,
	input wire logic                 RST_N,
	input wire logic [NUM_CORES-1:0] SECURE_WRITE_LOCK,
	input sswg_pkg::sswg_req_type    ACC_REQ [NUM_CORES],
	input sswg_pkg::sswg_rsp_type    ACC_RSP [NUM_CORES],
	input wire logic [NUM_CORES-1:0] WORLD_SELECT_BIT
);
	import sswg_pkg::*;
	sswg_req_type     q;
	logic [KEY_W-1:0] k;
	logic             pr;
	logic             s0;
	assign q = ACC_REQ[0];
	assign k = q[KEY_W-1:0];
	assign pr = k inside {KEY_SYSTEM_CONTROL, KEY_AUX_CONTROL, KEY_TABLE_BASE_0,
		KEY_TABLE_BASE_CTRL, KEY_DOMAIN_ACCESS, KEY_PRIMARY_REMAP, KEY_NORMAL_REMAP,
		KEY_VECTOR_BASE, KEY_MONITOR_VECTOR};
	// Secure copy targeted: world select in Monitor mode, else the core's own state
	assign s0 = q.monitor ? !WORLD_SELECT_BIT[0] : q.secure;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	sequence s_wr; q.valid && q.write; endsequence
	sequence s_rej; ##1 ACC_RSP[0].valid && ACC_RSP[0].undef; endsequence
	sequence s_ok; ##1 ACC_RSP[0].valid && !ACC_RSP[0].undef; endsequence
	property p_lock; s_wr ##0 (SECURE_WRITE_LOCK[0] && pr && s0) |-> s_rej; endproperty
	a_lock: assert property (p_lock) else $error("locked write accepted");
	property p_open; s_wr ##0 (!SECURE_WRITE_LOCK[0] && (q.monitor || q.secure)) |-> s_ok; endproperty
	a_open: assert property (p_open) else $error("unlocked write refused");
	property p_ns; s_wr ##0 (SECURE_WRITE_LOCK[0] && k == KEY_SYSTEM_CONTROL && !s0) |-> s_ok; endproperty
	a_ns: assert property (p_ns) else $error("nonsecure copy write refused");
	property p_read; q.valid && !q.write && (q.monitor || q.secure) |-> s_ok; endproperty
	a_read: assert property (p_read) else $error("secure read refused");
	property p_bank; q.valid && q.monitor && k == KEY_SYSTEM_CONTROL |=> ACC_RSP[0].bank_ns == $past(WORLD_SELECT_BIT[0]); endproperty
	a_bank: assert property (p_bank) else $error("monitor bank wrong");
	property p_kind; q.valid && k == KEY_SECURE_CONFIG |=> ACC_RSP[0].kind == KIND_SECURE_ONLY; endproperty
	a_kind: assert property (p_kind) else $error("register kind wrong");
	property p_core; ACC_REQ[1].valid && ACC_REQ[1].write && ACC_REQ[1].secure && !SECURE_WRITE_LOCK[1] |=> !ACC_RSP[1].undef; endproperty
	a_core: assert property (p_core) else $error("lock leaked across cores");
	property p_rst; $rose(RST_N) |-> WORLD_SELECT_BIT == '0; endproperty
	a_rst: assert property (p_rst) else $error("world select not clear");
endmodule : sswg_checker

/* dv/sswg_lock_model.sv */
`timescale 1ns/1ns
module sswg_lock_model #(
	parameter int NUM_CORES = 4
) (
	input  wire logic                 CLK_SYS,
	input  wire logic                 RST_N,
	input  wire logic [NUM_CORES-1:0] LOCK_WANT,
	output logic      [NUM_CORES-1:0] SECURE_WRITE_LOCK
);
	// Registered, as a boot-done flop would be, so changes land on clean edges
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) SECURE_WRITE_LOCK <= '0;
		else SECURE_WRITE_LOCK <= LOCK_WANT;
	end
endmodule : sswg_lock_model

/* dv/testbench.sv */
`timescale 1ns/1ns
module testbench;
	import sswg_pkg::*;
	typedef struct packed {
		logic             mon;
		logic             sec;
		logic             ws;
		logic [1:0]       lk;
		logic             wr;
		logic [KEY_W-1:0] key;
		logic             und;
	} sswg_row_type;
	logic             clk_sys = 1'b0;
	logic             rst_n = 1'b0;
	logic             cyc = 1'b0;
	logic             we = 1'b0;
	logic [ADR_W-1:0] adr = '0;
	logic [31:0]      dat = '0;
	logic [31:0]      rdat;
	logic [31:0]      q;
	logic             ack;
	logic             irq;
	logic [1:0]       want = '0;
	logic [1:0]       lock;
	logic [1:0]       wsb;
	sswg_req_type     req [2];
	sswg_rsp_type     rsp [2];
	int               num_errors = 0;
	int               tests_run = 0;
	sswg_row_type     rows [16] = '{
		'{0,1,0,1,1,KEY_SYSTEM_CONTROL,1}, '{0,0,0,1,1,KEY_AUX_CONTROL,1},
		'{0,1,0,1,1,KEY_TABLE_BASE_0,1}, '{0,1,0,1,1,KEY_TABLE_BASE_CTRL,1},
		'{0,1,0,1,1,KEY_DOMAIN_ACCESS,1}, '{0,1,0,1,1,KEY_PRIMARY_REMAP,1},
		'{0,1,0,1,1,KEY_NORMAL_REMAP,1}, '{0,1,0,1,1,KEY_VECTOR_BASE,1},
		'{1,0,0,1,1,KEY_MONITOR_VECTOR,1}, '{0,1,0,1,1,KEY_TABLE_BASE_1,0},
		'{0,0,1,1,1,KEY_DOMAIN_ACCESS,0}, '{1,0,1,1,1,KEY_SYSTEM_CONTROL,0},
		'{1,0,1,0,0,KEY_SECURE_CONFIG,0}, '{0,0,0,0,0,KEY_SECURE_CONFIG,1},
		'{0,1,0,1,0,KEY_VECTOR_BASE,0}, '{0,1,0,2,1,KEY_SYSTEM_CONTROL,0}};
	always #20 clk_sys = ~clk_sys;
	sswg_lock_model #(.NUM_CORES(2)) sswg_lock_model_inst (.CLK_SYS(clk_sys), .RST_N(rst_n),
		.LOCK_WANT(want), .SECURE_WRITE_LOCK(lock));
	sswg_gate #(.NUM_CORES(2)) sswg_gate_inst (.CLK_SYS(clk_sys), .RST_N(rst_n), .WB_CYC_I(cyc),
		.WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .SECURE_WRITE_LOCK(lock), .ACC_REQ(req),
		.ACC_RSP(rsp), .WORLD_SELECT_BIT(wsb), .IRQ(irq));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk_sys);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_sys); while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
	endtask : wb
	task automatic acc(input sswg_row_type r);
		wb(1'b1, ADR_WORLD_SELECT, {30'h0, r.ws, r.ws}, q);
		want <= r.lk;
		@(posedge clk_sys);
		req[0] <= {1'b1, r.wr, r.mon, r.sec, r.key};
		req[1] <= {1'b1, r.wr, r.mon, r.sec, r.key};
		@(posedge clk_sys);
		req[0].valid <= 1'b0;
		req[1].valid <= 1'b0;
		#1;
		chk("world select", {r.ws, r.ws}, wsb);
		chk("valid", 1, rsp[0].valid);
		chk("undef", r.und, rsp[0].undef);
		if (r.key == KEY_SYSTEM_CONTROL) chk("bank", r.mon ? r.ws : !r.sec, rsp[0].bank_ns);
	endtask : acc
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_of_test
	// Under 150 cycles are needed; twenty times that means a hang
	initial begin
		repeat (3000) @(posedge clk_sys);
		num_errors++;
		end_of_test;
	end
	initial begin
		req[0] = '0;
		req[1] = '0;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		#1 chk("reset world select", 0, wsb);
		wb(1'b0, ADR_IRQ_MASK, 0, q);
		chk("reset mask", RST_IRQ_MASK, q);
		for (int i = 0; i < 16; i++) begin
			acc(rows[i]);
			$display("row %0d done", i);
		end
		wb(1'b0, ADR_LOCK_VIEW, 0, q);
		chk("lock view", 32'h0000_0002, q);
		chk("irq masked", 0, irq);
		wb(1'b0, ADR_IRQ_STATUS, 0, q);
		chk("status", 32'h0000_0003, q);
		wb(1'b1, ADR_IRQ_MASK, 32'h0000_0002, q);
		@(posedge clk_sys);
		#1 chk("irq raised", 1, irq);
		wb(1'b1, ADR_IRQ_STATUS, 32'h0000_0002, q);
		@(posedge clk_sys);
		#1 chk("irq cleared", 0, irq);
		wb(1'b0, ADR_IRQ_STATUS, 0, q);
		chk("status after clear", 32'h0000_0001, q);
		wb(1'b0, 8'h40, 0, q);
		chk("unmapped", 0, q);
		$display("register tests done");
		wb(1'b1, ADR_IRQ_MASK, 32'h0000_0003, q);
		wb(1'b1, ADR_WORLD_SELECT, 32'h0000_0003, q);
		@(posedge clk_sys);
		#1 chk("irq before reset", 1, irq);
		chk("world before reset", 32'h0000_0003, wsb);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		#1 chk("mid reset world select", 0, wsb);
		chk("mid reset irq", 0, irq);
		wb(1'b0, ADR_IRQ_STATUS, 0, q);
		chk("mid reset status", RST_IRQ_STATUS, q);
		$display("mid reset test done");
		end_of_test;
	end
endmodule : testbench
bind sswg_gate sswg_checker #(.NUM_CORES(NUM_CORES)) sswg_checker_inst (.CLK_SYS(CLK_SYS),
	.RST_N(RST_N), .SECURE_WRITE_LOCK(SECURE_WRITE_LOCK), .ACC_REQ(ACC_REQ),
	.ACC_RSP(ACC_RSP), .WORLD_SELECT_BIT(WORLD_SELECT_BIT));

/* hdl/sswg_gate.sv */
`timescale 1ns/1ns
module sswg_gate #(
	parameter int NUM_CORES = 4
) (
	input  wire logic                  CLK_SYS,
	input  wire logic                  RST_N,
	input  wire logic                  WB_CYC_I,
	input  wire logic                  WB_STB_I,
	input  wire logic                  WB_WE_I,
	input  wire logic [sswg_pkg::ADR_W-1:0] WB_ADR_I,
	input  wire logic [3:0]            WB_SEL_I,
	input  wire logic [31:0]           WB_DAT_I,
	output logic      [31:0]           WB_DAT_O,
	output logic                       WB_ACK_O,
	input  wire logic [NUM_CORES-1:0]  SECURE_WRITE_LOCK,
	input  sswg_pkg::sswg_req_type     ACC_REQ [NUM_CORES],
	output sswg_pkg::sswg_rsp_type     ACC_RSP [NUM_CORES],
	output logic [NUM_CORES-1:0]       WORLD_SELECT_BIT,
	output logic                       IRQ
);
	import sswg_pkg::*;

	typedef struct packed {
		logic [31:0]                 dat;
		logic                        ack;
		logic [NUM_CORES-1:0]        world;
		logic [NUM_CORES-1:0]        status;
		logic [NUM_CORES-1:0]        mask;
		logic                        irq;
		sswg_rsp_type [NUM_CORES-1:0] rsp;
	} sswg_state_type;

	sswg_state_type state_ff;
	sswg_state_type nxt_state;

	// Secure-only, banked or common, and whether the lock guards it
	function automatic sswg_kind_type reg_kind(input logic [KEY_W-1:0] key);
		case (key)
			KEY_SECURE_CONFIG,
			KEY_SECURE_DEBUG,
			KEY_NS_ACCESS_CTRL,
			KEY_MONITOR_VECTOR:  reg_kind = KIND_SECURE_ONLY;
			KEY_SYSTEM_CONTROL,
			KEY_TABLE_BASE_0,
			KEY_TABLE_BASE_1,
			KEY_TABLE_BASE_CTRL,
			KEY_DOMAIN_ACCESS,
			KEY_PRIMARY_REMAP,
			KEY_NORMAL_REMAP,
			KEY_VECTOR_BASE:     reg_kind = KIND_BANKED;
			default:             reg_kind = KIND_COMMON;
		endcase
	endfunction : reg_kind

	function automatic logic is_protected(input logic [KEY_W-1:0] key);
		case (key)
			KEY_SYSTEM_CONTROL,
			KEY_AUX_CONTROL:     is_protected = 1'b1;
			KEY_TABLE_BASE_0,
			KEY_TABLE_BASE_CTRL,
			KEY_DOMAIN_ACCESS:   is_protected = 1'b1;
			KEY_PRIMARY_REMAP,
			KEY_NORMAL_REMAP:    is_protected = 1'b1;
			KEY_VECTOR_BASE,
			KEY_MONITOR_VECTOR:  is_protected = 1'b1;
			default:             is_protected = 1'b0;
		endcase
	endfunction : is_protected

	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : lane_mask

	logic                 bus_req;
	logic                 bus_wr;
	logic [31:0]          wmask;
	logic [NUM_CORES-1:0] wbits;
	logic [NUM_CORES-1:0] wmask_n;
	logic [NUM_CORES-1:0] undef_evt;

	always_comb begin
		logic [KEY_W-1:0] key;
		logic             eff_secure;
		logic             bank_ns;
		logic             secure_copy;
		logic             locked_out;
		logic             priv_fail;
		sswg_kind_type    kind;
		key         = '0;
		eff_secure  = 1'b0;
		bank_ns     = 1'b0;
		secure_copy = 1'b0;
		locked_out  = 1'b0;
		priv_fail   = 1'b0;
		kind        = KIND_COMMON;
		nxt_state   = state_ff;
		undef_evt   = '0;

		// Per-core decode; lock bits are used unregistered so a change
		// reaches the very next decoded access.
		for (int c = 0; c < NUM_CORES; c++) begin
			key = {ACC_REQ[c].crn, ACC_REQ[c].opc1, ACC_REQ[c].crm, ACC_REQ[c].opc2};
			kind = reg_kind(key);
			// Monitor mode is Secure whatever the world select bit says
			eff_secure = ACC_REQ[c].monitor | ACC_REQ[c].secure;
			// Monitor picks the bank from the world select bit, others by state
			bank_ns = ACC_REQ[c].monitor ? state_ff.world[c] : ~ACC_REQ[c].secure;
			// Secure-only registers need Secure state; monitor always has it
			priv_fail = (kind == KIND_SECURE_ONLY) && !eff_secure;
			// Nonbanked registers have a single copy that counts as the Secure copy
			secure_copy = (kind != KIND_BANKED) || !bank_ns;
			locked_out = SECURE_WRITE_LOCK[c] && ACC_REQ[c].write
				&& is_protected(key) && secure_copy;
			nxt_state.rsp[c].valid   = ACC_REQ[c].valid;
			nxt_state.rsp[c].undef   = ACC_REQ[c].valid && (locked_out || priv_fail);
			nxt_state.rsp[c].bank_ns = (kind == KIND_BANKED) ? bank_ns : 1'b0;
			nxt_state.rsp[c].kind    = kind;
			undef_evt[c] = ACC_REQ[c].valid && (locked_out || priv_fail);
		end

		// Classic Wishbone slave, one wait state, ack drops between cycles
		bus_req = WB_CYC_I && WB_STB_I && !state_ff.ack;
		// Writes land on the edge that sees ack high, where the master commits
		bus_wr  = WB_CYC_I && WB_STB_I && WB_WE_I && state_ff.ack;
		wmask   = lane_mask(WB_SEL_I);
		wbits   = WB_DAT_I[NUM_CORES-1:0];
		wmask_n = wmask[NUM_CORES-1:0];
		nxt_state.ack = bus_req;
		nxt_state.dat = 32'h0000_0000;

		if (bus_req && !WB_WE_I) begin
			case (WB_ADR_I)
				ADR_WORLD_SELECT: nxt_state.dat[NUM_CORES-1:0] = state_ff.world;
				ADR_LOCK_VIEW:    nxt_state.dat[NUM_CORES-1:0] = SECURE_WRITE_LOCK;
				ADR_IRQ_STATUS:   nxt_state.dat[NUM_CORES-1:0] = state_ff.status;
				ADR_IRQ_MASK:     nxt_state.dat[NUM_CORES-1:0] = state_ff.mask;
				default:          nxt_state.dat = 32'h0000_0000;
			endcase
		end

		if (bus_wr && WB_ADR_I == ADR_WORLD_SELECT) begin
			nxt_state.world = (state_ff.world & ~wmask_n) | (wbits & wmask_n);
		end
		if (bus_wr && WB_ADR_I == ADR_IRQ_MASK) begin
			nxt_state.mask = (state_ff.mask & ~wmask_n) | (wbits & wmask_n);
		end
		if (bus_wr && WB_ADR_I == ADR_IRQ_STATUS) begin
			nxt_state.status = state_ff.status & ~(wbits & wmask_n);
		end
		// A reject in the clearing cycle is kept
		nxt_state.status = nxt_state.status | undef_evt;
		nxt_state.irq = |(nxt_state.status & nxt_state.mask);
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			state_ff        <= '0;
			state_ff.world  <= RST_WORLD_SELECT[NUM_CORES-1:0];
			state_ff.status <= RST_IRQ_STATUS[NUM_CORES-1:0];
			state_ff.mask   <= RST_IRQ_MASK[NUM_CORES-1:0];
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign WB_DAT_O         = state_ff.dat;
	assign WB_ACK_O         = state_ff.ack;
	assign WORLD_SELECT_BIT = state_ff.world;
	assign IRQ              = state_ff.irq;
	for (genvar g = 0; g < NUM_CORES; g++) begin : g_rsp
		assign ACC_RSP[g] = state_ff.rsp[g];
	end

endmodule : sswg_gate

/* pkg/sswg_pkg.sv */
package sswg_pkg;

	// Register key: {crn, opc1, crm, opc2}
	localparam int KEY_W = 14;

	localparam logic [KEY_W-1:0] KEY_SYSTEM_CONTROL  = {4'h1, 3'h0, 4'h0, 3'h0};
	localparam logic [KEY_W-1:0] KEY_AUX_CONTROL     = {4'h1, 3'h0, 4'h0, 3'h1};
	localparam logic [KEY_W-1:0] KEY_SECURE_CONFIG   = {4'h1, 3'h0, 4'h1, 3'h0};
	localparam logic [KEY_W-1:0] KEY_SECURE_DEBUG    = {4'h1, 3'h0, 4'h1, 3'h1};
	localparam logic [KEY_W-1:0] KEY_NS_ACCESS_CTRL  = {4'h1, 3'h0, 4'h1, 3'h2};
	localparam logic [KEY_W-1:0] KEY_TABLE_BASE_0    = {4'h2, 3'h0, 4'h0, 3'h0};
	localparam logic [KEY_W-1:0] KEY_TABLE_BASE_1    = {4'h2, 3'h0, 4'h0, 3'h1};
	localparam logic [KEY_W-1:0] KEY_TABLE_BASE_CTRL = {4'h2, 3'h0, 4'h0, 3'h2};
	localparam logic [KEY_W-1:0] KEY_DOMAIN_ACCESS   = {4'h3, 3'h0, 4'h0, 3'h0};
	localparam logic [KEY_W-1:0] KEY_PRIMARY_REMAP   = {4'hA, 3'h0, 4'h2, 3'h0};
	localparam logic [KEY_W-1:0] KEY_NORMAL_REMAP    = {4'hA, 3'h0, 4'h2, 3'h1};
	localparam logic [KEY_W-1:0] KEY_VECTOR_BASE     = {4'hC, 3'h0, 4'h0, 3'h0};
	localparam logic [KEY_W-1:0] KEY_MONITOR_VECTOR  = {4'hC, 3'h0, 4'h0, 3'h1};

	// Wishbone register byte addresses
	localparam int ADR_W = 8;
	localparam logic [ADR_W-1:0] ADR_WORLD_SELECT = 8'h00;
	localparam logic [ADR_W-1:0] ADR_LOCK_VIEW    = 8'h04;
	localparam logic [ADR_W-1:0] ADR_IRQ_STATUS   = 8'h08;
	localparam logic [ADR_W-1:0] ADR_IRQ_MASK     = 8'h0C;

	localparam logic [31:0] RST_WORLD_SELECT = 32'h0000_0000;
	localparam logic [31:0] RST_IRQ_STATUS   = 32'h0000_0000;
	localparam logic [31:0] RST_IRQ_MASK     = 32'h0000_0000;

	typedef enum logic [1:0] {
		KIND_COMMON      = 2'b00,
		KIND_BANKED      = 2'b01,
		KIND_SECURE_ONLY = 2'b10
	} sswg_kind_type;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic       monitor;
		logic       secure;
		logic [3:0] crn;
		logic [2:0] opc1;
		logic [3:0] crm;
		logic [2:0] opc2;
	} sswg_req_type;

	typedef struct packed {
		logic          valid;
		logic          undef;
		logic          bank_ns;
		sswg_kind_type kind;
	} sswg_rsp_type;

endpackage : sswg_pkg
